// ### gpio_edge_enable_set_clear.v
// gpio edge enables with bitwise set/clear, edge status and pass mask
//
// How it works
// - one in rise-clear word clears enable
// - zeros in set/clear words change nothing
// - one in fall-set word sets enable
// - one in fall-clear word clears enable
// - mask zero blocks edge, one passes
// - masks read/write, reset to zero
// - high group bits 17:0 only, rest zero
// - set/clear words write-only, hold nothing
// - enabled rising edge sets status bit
// - enabled falling edge sets status bit
// - status sticky, write one clears
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "gpio_edge_map.vh"
module gpio_edge_enable_set_clear (
	// clock and reset
	input  wire                 clock,
	input  wire                 resetn,
	// register port
	input  wire [`ADDR_W-1:0]   addr,
	input  wire [`DATA_W-1:0]   wdata,
	input  wire                 wr_en,
	input  wire                 rd_en,
	output reg  [`DATA_W-1:0]   rdata_reg,
	// gpio pins
	input  wire [`LO_W-1:0]     gpio_in_lo,
	input  wire [`HI_W-1:0]     gpio_in_hi,
	// edge interrupt
	output reg                  irq_reg
);

	// address match helper
	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// high group word, upper bits zero
	function [`DATA_W-1:0] ext_hi;
		input [`HI_W-1:0] v;
		begin
			ext_hi = {{`HI_PAD{1'b0}}, v};
		end
	endfunction

	// edge pulses from synchronised pins
	wire [`LO_W-1:0] rise_lo;
	wire [`LO_W-1:0] fall_lo;
	wire [`HI_W-1:0] rise_hi;
	wire [`HI_W-1:0] fall_hi;

	// enable registers
	wire [`LO_W-1:0] rise_en_lo;
	wire [`HI_W-1:0] rise_en_hi;
	wire [`LO_W-1:0] fall_en_lo;
	wire [`HI_W-1:0] fall_en_hi;

	// status and mask state
	reg  [`LO_W-1:0] status_lo_reg;
	reg  [`LO_W-1:0] status_lo_next;
	reg  [`HI_W-1:0] status_hi_reg;
	reg  [`HI_W-1:0] status_hi_next;
	reg  [`LO_W-1:0] mask_lo_reg;
	reg  [`LO_W-1:0] mask_lo_next;
	reg  [`HI_W-1:0] mask_hi_reg;
	reg  [`HI_W-1:0] mask_hi_next;
	reg  [`DATA_W-1:0] rdata_next;

	// high group write data, reserved bits dropped
	wire [`HI_W-1:0] wdata_hi;
	assign wdata_hi = wdata[`HI_W-1:0];

	// write strobes per register
	wire wr_rise_en_lo;
	wire wr_rise_en_hi;
	wire wr_fall_en_lo;
	wire wr_fall_en_hi;
	wire wr_status_lo;
	wire wr_status_hi;
	wire wr_rise_set_lo;
	wire wr_rise_set_hi;
	wire wr_rise_clr_lo;
	wire wr_rise_clr_hi;
	wire wr_fall_set_lo;
	wire wr_fall_set_hi;
	wire wr_fall_clr_lo;
	wire wr_fall_clr_hi;
	wire wr_mask_lo;
	wire wr_mask_hi;

	// address decode of writes
	assign wr_rise_en_lo  = wr_en & hit(addr, `OFF_RISE_EN_LO);
	assign wr_rise_en_hi  = wr_en & hit(addr, `OFF_RISE_EN_HI);
	assign wr_fall_en_lo  = wr_en & hit(addr, `OFF_FALL_EN_LO);
	assign wr_fall_en_hi  = wr_en & hit(addr, `OFF_FALL_EN_HI);
	assign wr_status_lo   = wr_en & hit(addr, `OFF_STATUS_LO);
	assign wr_status_hi   = wr_en & hit(addr, `OFF_STATUS_HI);
	assign wr_rise_set_lo = wr_en & hit(addr, `OFF_RISE_SET_LO);
	assign wr_rise_set_hi = wr_en & hit(addr, `OFF_RISE_SET_HI);
	assign wr_rise_clr_lo = wr_en & hit(addr, `OFF_RISE_CLEAR_LO);
	assign wr_rise_clr_hi = wr_en & hit(addr, `OFF_RISE_CLEAR_HI);
	assign wr_fall_set_lo = wr_en & hit(addr, `OFF_FALL_SET_LO);
	assign wr_fall_set_hi = wr_en & hit(addr, `OFF_FALL_SET_HI);
	assign wr_fall_clr_lo = wr_en & hit(addr, `OFF_FALL_CLEAR_LO);
	assign wr_fall_clr_hi = wr_en & hit(addr, `OFF_FALL_CLEAR_HI);
	assign wr_mask_lo     = wr_en & hit(addr, `OFF_MASK_LO);
	assign wr_mask_hi     = wr_en & hit(addr, `OFF_MASK_HI);

	// pin synchronisers and edge detect, low group
	edge_sync_detect #(
		.WIDTH      (`LO_W)
	) u_sync_lo (
		.clock      (clock),
		.resetn     (resetn),
		.pin_in     (gpio_in_lo),
		.rise_pulse (rise_lo),
		.fall_pulse (fall_lo)
	);

	// pin synchronisers and edge detect, high group
	edge_sync_detect #(
		.WIDTH      (`HI_W)
	) u_sync_hi (
		.clock      (clock),
		.resetn     (resetn),
		.pin_in     (gpio_in_hi),
		.rise_pulse (rise_hi),
		.fall_pulse (fall_hi)
	);

	enable_bank #(
		.WIDTH     (`LO_W)
	) u_rise_lo (
		.clock     (clock),
		.resetn    (resetn),
		.write_stb (wr_rise_en_lo),
		.set_stb   (wr_rise_set_lo),
		.clear_stb (wr_rise_clr_lo),
		.wdata     (wdata),
		.en_reg    (rise_en_lo)
	);

	enable_bank #(
		.WIDTH     (`HI_W)
	) u_rise_hi (
		.clock     (clock),
		.resetn    (resetn),
		.write_stb (wr_rise_en_hi),
		.set_stb   (wr_rise_set_hi),
		.clear_stb (wr_rise_clr_hi),
		.wdata     (wdata_hi),
		.en_reg    (rise_en_hi)
	);

	enable_bank #(
		.WIDTH     (`LO_W)
	) u_fall_lo (
		.clock     (clock),
		.resetn    (resetn),
		.write_stb (wr_fall_en_lo),
		.set_stb   (wr_fall_set_lo),
		.clear_stb (wr_fall_clr_lo),
		.wdata     (wdata),
		.en_reg    (fall_en_lo)
	);

	// falling enables, high group
	enable_bank #(
		.WIDTH     (`HI_W)
	) u_fall_hi (
		.clock     (clock),
		.resetn    (resetn),
		.write_stb (wr_fall_en_hi),
		.set_stb   (wr_fall_set_hi),
		.clear_stb (wr_fall_clr_hi),
		.wdata     (wdata_hi),
		.en_reg    (fall_en_hi)
	);

	wire [`LO_W-1:0] seen_lo;
	wire [`HI_W-1:0] seen_hi;
	assign seen_lo = (rise_lo & rise_en_lo) | (fall_lo & fall_en_lo);
	assign seen_hi = (rise_hi & rise_en_hi) | (fall_hi & fall_en_hi);

	always @* begin
		status_lo_next = status_lo_reg;
		status_hi_next = status_hi_reg;
		if (wr_status_lo) begin
			status_lo_next = status_lo_reg & ~wdata;
		end
		if (wr_status_hi) begin
			status_hi_next = status_hi_reg & ~wdata_hi;
		end
		status_lo_next = status_lo_next | seen_lo; // set after clear, set wins
		status_hi_next = status_hi_next | seen_hi;
	end

	// status registers
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status_lo_reg <= `RST_LO;
			status_hi_reg <= `RST_HI;
		end else begin
			status_lo_reg <= status_lo_next;
			status_hi_reg <= status_hi_next;
		end
	end

	// mask words, whole word replaced on write
	always @* begin
		mask_lo_next = mask_lo_reg;
		mask_hi_next = mask_hi_reg;
		if (wr_mask_lo) begin
			mask_lo_next = wdata;
		end
		if (wr_mask_hi) begin
			mask_hi_next = wdata_hi;
		end
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mask_lo_reg <= `RST_LO;
			mask_hi_reg <= `RST_HI;
		end else begin
			mask_lo_reg <= mask_lo_next;
			mask_hi_reg <= mask_hi_next;
		end
	end

	wire [`LO_W-1:0] pass_lo;
	wire [`HI_W-1:0] pass_hi;
	assign pass_lo = status_lo_next & mask_lo_reg;
	assign pass_hi = status_hi_next & mask_hi_reg;

	wire irq_next;
	assign irq_next = (|pass_lo) | (|pass_hi);

	// event level registered so the pin leaves a flop
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// read mux; write-only and unmapped read zero
	always @* begin
		rdata_next = `RST_WORD;
		case (addr)
			`OFF_RISE_EN_LO: begin
				rdata_next = rise_en_lo;
			end
			`OFF_RISE_EN_HI: begin
				rdata_next = ext_hi(rise_en_hi);
			end
			`OFF_FALL_EN_LO: begin
				rdata_next = fall_en_lo;
			end
			`OFF_FALL_EN_HI: begin
				rdata_next = ext_hi(fall_en_hi);
			end
			`OFF_STATUS_LO: begin
				rdata_next = status_lo_reg;
			end
			`OFF_STATUS_HI: begin
				rdata_next = ext_hi(status_hi_reg);
			end
			`OFF_MASK_LO: begin
				rdata_next = mask_lo_reg;
			end
			`OFF_MASK_HI: begin
				rdata_next = ext_hi(mask_hi_reg);
			end
			default: begin
				rdata_next = `RST_WORD;
			end
		endcase
	end

	// read data valid the cycle after rd_en only
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= `RST_WORD;
		end else if (rd_en) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= `RST_WORD;
		end
	end

endmodule // gpio_edge_enable_set_clear

// ### gpio_edge_map.vh
// register map and field constants for the gpio edge enable block
`ifndef GPIO_EDGE_MAP_VH
`define GPIO_EDGE_MAP_VH

// bus widths and pin group sizes
`define ADDR_W        8
`define DATA_W        32
`define LO_W          32
`define HI_W          18
`define HI_PAD        14

// edge enable registers, read/write
`define OFF_RISE_EN_LO      8'h30
`define OFF_RISE_EN_HI      8'h34
`define OFF_FALL_EN_LO      8'h3c
`define OFF_FALL_EN_HI      8'h40

// edge status registers, write one to clear
`define OFF_STATUS_LO       8'h48
`define OFF_STATUS_HI       8'h4c

// write-only set and clear registers
`define OFF_RISE_SET_LO     8'h6c
`define OFF_RISE_SET_HI     8'h70
`define OFF_RISE_CLEAR_LO   8'h78
`define OFF_RISE_CLEAR_HI   8'h7c
`define OFF_FALL_SET_LO     8'h84
`define OFF_FALL_SET_HI     8'h88
`define OFF_FALL_CLEAR_LO   8'h90
`define OFF_FALL_CLEAR_HI   8'h94

// edge pass masks, read/write
`define OFF_MASK_LO         8'h9c
`define OFF_MASK_HI         8'ha0

// reset values
`define RST_WORD            32'h0000_0000
`define RST_LO              32'h0000_0000
`define RST_HI              18'h0_0000

`endif

// ### edge_sync_detect.v
// two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module edge_sync_detect #(
	parameter WIDTH = 32
) (
	// clock and reset
	input  wire             clock,
	input  wire             resetn,
	// raw pins
	input  wire [WIDTH-1:0] pin_in,
	// one-cycle edge pulses
	output wire [WIDTH-1:0] rise_pulse,
	output wire [WIDTH-1:0] fall_pulse
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	reg [WIDTH-1:0] prev_reg;

	// meta_reg feeds only sync_reg
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
			prev_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// edges seen between synced samples
	assign rise_pulse = sync_reg & ~prev_reg;
	assign fall_pulse = ~sync_reg & prev_reg;

endmodule // edge_sync_detect

// ### enable_bank.v
// one edge enable register with direct write and bitwise set/clear
`timescale 1ns/1ps
module enable_bank #(
	parameter WIDTH = 32
) (
	// clock and reset
	input  wire             clock,
	input  wire             resetn,
	// write strobes
	input  wire             write_stb,
	input  wire             set_stb,
	input  wire             clear_stb,
	input  wire [WIDTH-1:0] wdata,
	// enable bits
	output reg  [WIDTH-1:0] en_reg
);

	reg [WIDTH-1:0] en_next;

	// direct write replaces the word; in set and clear only ones change bits
	always @* begin
		en_next = en_reg;
		if (write_stb) begin
			en_next = wdata;
		end else if (set_stb) begin
			en_next = en_reg | wdata;
		end else if (clear_stb) begin
			en_next = en_reg & ~wdata;
		end
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			en_reg <= {WIDTH{1'b0}};
		end else begin
			en_reg <= en_next;
		end
	end

endmodule // enable_bank

// ### gpio_edge_sva.sv
// port assertions for the gpio edge enable block
`timescale 1ns/1ps
module gpio_edge_sva (
	// clock and reset
	input logic        clock,
	input logic        resetn,
	// register port
	input logic [7:0]  addr,
	input logic [31:0] wdata,
	input logic        wr_en,
	input logic        rd_en,
	input logic [31:0] rdata_reg,
	// pins and event
	input logic [31:0] gpio_in_lo,
	input logic [17:0] gpio_in_hi,
	input logic        irq_reg
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_RISE_CLR: assert property (
		wr_en && addr == 8'h78 ##1 rd_en && addr == 8'h30 |=> !(rdata_reg & $past(wdata, 2)))
		else $error("rise clear left a bit set");
	AST_FALL_SET: assert property (
		wr_en && addr == 8'h84 ##1 rd_en && addr == 8'h3c
		|=> (rdata_reg & $past(wdata, 2)) == $past(wdata, 2)) else $error("fall set missed a bit");
	AST_FALL_CLR: assert property (
		wr_en && addr == 8'h90 ##1 rd_en && addr == 8'h3c |=> !(rdata_reg & $past(wdata, 2)))
		else $error("fall clear left a bit set");
	AST_MASK_OFF: assert property (
		wr_en && addr == 8'h9c && wdata == '0 ##1 wr_en && addr == 8'ha0 && wdata == '0
		|=> ##1 !irq_reg) else $error("event passed a zero mask");
	AST_MASK_RW: assert property (
		wr_en && addr == 8'h9c ##1 rd_en && addr == 8'h9c |=> rdata_reg == $past(wdata, 2))
		else $error("mask read back differs");
	AST_HI_RSVD: assert property (
		rd_en && (addr == 8'ha0 || addr == 8'h34) |=> rdata_reg[31:18] == 14'h0000)
		else $error("reserved high bits not zero");
	AST_WO_READ: assert property (
		rd_en && addr == 8'h84 |=> rdata_reg == '0) else $error("write-only word read nonzero");
	AST_IRQ_FALL: assert property (
		$fell(irq_reg) |-> $past(wr_en) || $past(wr_en, 2)) else $error("event fell without write");
endmodule // gpio_edge_sva

bind gpio_edge_enable_set_clear gpio_edge_sva u_sva (.clock(clock), .resetn(resetn),
	.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_reg(rdata_reg),
	.gpio_in_lo(gpio_in_lo), .gpio_in_hi(gpio_in_hi), .irq_reg(irq_reg));

// ### pin_source.sv
// outside world driving the gpio pins
`timescale 1ns/1ps
module pin_source (
	// requested levels
	input  logic [31:0] lo_req,
	input  logic [17:0] hi_req,
	// pins seen by the block
	output wire  [31:0] gpio_in_lo,
	output wire  [17:0] gpio_in_hi
);
	// pins move off the clock edge, as real inputs do
	assign #3 gpio_in_lo = lo_req;
	assign #3 gpio_in_hi = hi_req;
endmodule // pin_source

// ### tb_top.sv
// self-checking bench for the gpio edge enable block
`timescale 1ns/1ps
module tb_top;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  addr = '0;
	logic [31:0] wdata = '0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        pend = 1'b0;
	logic [31:0] lo_req = '0;
	logic [17:0] hi_req = '0;
	wire  [31:0] rdata_reg, gpio_in_lo;
	wire  [17:0] gpio_in_hi;
	wire         irq_reg;
	logic [31:0] re [2] = '{'0, '0}, fe [2] = '{'0, '0}, mk [2] = '{'0, '0}, st [2] = '{'0, '0};
	logic [31:0] q [$];
	logic [31:0] d, olo, ohi;
	integer      mismatches = 0, checks = 0, seed = 97398, i, j;
	logic [7:0]  wa [13] = '{8'h78, 8'h84, 8'h90, 8'h9c, 8'h6c, 8'h70, 8'h7c, 8'h88, 8'h94,
		8'ha0, 8'h30, 8'h3c, 8'h34};
	logic [7:0]  ra [13] = '{8'h30, 8'h3c, 8'h3c, 8'h9c, 8'h30, 8'h34, 8'h34, 8'h40, 8'h40,
		8'ha0, 8'h30, 8'h3c, 8'h34};

	gpio_edge_enable_set_clear u_dut (.clock(clock), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_reg(rdata_reg),
		.gpio_in_lo(gpio_in_lo), .gpio_in_hi(gpio_in_hi), .irq_reg(irq_reg));
	pin_source u_pins (.lo_req(lo_req), .hi_req(hi_req), .gpio_in_lo(gpio_in_lo),
		.gpio_in_hi(gpio_in_hi));

	// clock and watchdog
	initial forever #4 clock = ~clock;
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// expected read value of each register
	function automatic logic [31:0] peek(input logic [7:0] a);
		case (a)
		8'h30: return re[0];
		8'h34: return re[1];
		8'h3c: return fe[0];
		8'h40: return fe[1];
		8'h48: return st[0];
		8'h4c: return st[1];
		8'h9c: return mk[0];
		8'ha0: return mk[1];
		default: return '0;
		endcase
	endfunction

	// one write cycle, model updated alongside
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		case (a)
		8'h30: re[0] = v;
		8'h34: re[1] = v;
		8'h3c: fe[0] = v;
		8'h48: st[0] &= ~v;
		8'h4c: st[1] &= ~v;
		8'h6c: re[0] |= v;
		8'h70: re[1] |= v;
		8'h78: re[0] &= ~v;
		8'h7c: re[1] &= ~v;
		8'h84: fe[0] |= v;
		8'h88: fe[1] |= v;
		8'h90: fe[0] &= ~v;
		8'h94: fe[1] &= ~v;
		8'h9c: mk[0] = v;
		8'ha0: mk[1] = v;
		endcase
	endtask

	// one read cycle, data checked in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		q.push_back(peek(a));
	endtask
	always @(posedge clock) pend <= rd_en;
	always @(negedge clock) if (pend) cmp(rdata_reg, q.pop_front());

	// random pin change, then status and event predicted
	task automatic pins();
		olo = lo_req;
		ohi = 32'(hi_req);
		@(posedge clock);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		lo_req <= $random(seed);
		hi_req <= $random(seed);
		repeat (6) @(posedge clock);
		st[0] |= (lo_req & ~olo & re[0]) | (~lo_req & olo & fe[0]);
		st[1] |= (32'(hi_req) & ~ohi & re[1]) | (~32'(hi_req) & ohi & fe[1]);
		@(negedge clock);
		cmp(32'(irq_reg), 32'(|(st[0] & mk[0]) | |(st[1] & mk[1])));
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		for (i = 0; i < 13; i++) rd(ra[i]);
		rd(8'h84);
		rd(8'h00);
		for (j = 0; j < 12; j++) begin
			for (i = 0; i < 13; i++) begin
				d = $random(seed);
				if (ra[i] inside {8'h34, 8'h40, 8'ha0}) d[31:18] = 14'h0000;
				wr(wa[i], d);
				rd(ra[i]);
			end
			pins();
			rd(8'h48);
			rd(8'h4c);
			wr(8'h48, j[0] ? st[0] : 32'($random(seed)));
			wr(8'h4c, st[1]);
			rd(8'h48);
			rd(8'ha0);
		end
		wr(8'h9c, '0);
		wr(8'ha0, '0);
		pins();
		tally_and_finish();
	end
endmodule // tb_top
